// *** common/ssp_pkg.sv ***
// shared constants and types for the synchronous serial port
// assumes a single 20 MHz system clock and no software register map
package ssp_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int         SSP_DW        = 16;
  localparam int         SSP_DEPTH     = 8;
  localparam logic [3:0] SSP_FIFO_FULL = 4'h8;
  localparam logic [3:0] SSP_LEN_MIN   = 4'h3;
  // a half bit under three clocks would sample rxd before it clears the synchroniser
  localparam logic [7:0] SSP_PRE_MIN   = 8'h03;
  localparam logic [3:0] SSP_MSB       = 4'hF;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SSP_FMT_SPI   = 2'b00,
    SSP_FMT_PULSE = 2'b01,
    SSP_FMT_SELHI = 2'b10
  } ssp_fmt_t;

  typedef enum logic [1:0] {
    SSP_ST_IDLE  = 2'b00,
    SSP_ST_PULSE = 2'b01,
    SSP_ST_SHIFT = 2'b10,
    SSP_ST_GAP   = 2'b11
  } ssp_state_t;

  typedef struct packed {
    logic       enable;
    logic       slave;
    logic       out_dis;
    ssp_fmt_t   fmt;
    logic [3:0] len_m1;
    logic [7:0] pre;
    logic [7:0] div;
  } ssp_cfg_t;

  function automatic logic [2:0] ssp_inc(input logic [2:0] p);
    ssp_inc = p + 3'h1;
  endfunction
endpackage

// *** hw/ssp_core.sv ***
// synchronous serial port: fifos, master clock generator, shift engine
// assumes config is static while a frame is in flight; link pins are async
`timescale 1ns/100ps
module ssp_core (
  // clock, reset, enable
  input  wire logic               i_clk_sys,
  input  wire logic               i_resetn,
  input  wire logic               i_ce,
  // configuration
  input  wire ssp_pkg::ssp_cfg_t  i_cfg,
  // transmit words
  input  wire logic               i_tx_valid,
  input  wire logic [15:0]        i_tx_data,
  output logic                    o_tx_ready,
  // receive words
  output logic                    o_rx_valid,
  output logic [15:0]             o_rx_data,
  input  wire logic               i_rx_ready,
  // link
  input  wire logic               i_sclk,
  output logic                    o_sclk,
  output logic                    o_sclk_oe,
  input  wire logic               i_frm,
  output logic                    o_frm,
  output logic                    o_frm_oe,
  output logic                    o_txd,
  output logic                    o_txd_oe,
  input  wire logic               i_rxd,
  // status
  output logic                    o_busy,
  output logic                    o_overrun
);
  import ssp_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [15:0] tx_mem_ff [SSP_DEPTH];
  logic [15:0] rx_mem_ff [SSP_DEPTH];
  logic [2:0]  tx_wr_ff, tx_rd_ff, rx_wr_ff, rx_rd_ff;
  logic [3:0]  tx_cnt_ff, rx_cnt_ff;
  ssp_state_t  state_ff, nxt_state;
  logic [15:0] sh_tx_ff, sh_rx_ff, nxt_sh_tx, nxt_sh_rx, o_rx_data_ff;
  logic [3:0]  bit_ff, nxt_bit;
  logic [7:0]  pre_cnt_ff, div_cnt_ff;
  logic        phase_ff, nxt_phase;
  logic [2:0]  sclk_s_ff, frm_s_ff;
  logic [1:0]  rxd_s_ff;
  logic        o_tx_ready_ff, o_rx_valid_ff, o_sclk_ff, o_frm_ff, o_txd_ff;
  logic        o_sclk_oe_ff, o_frm_oe_ff, o_txd_oe_ff, o_busy_ff, o_overrun_ff;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire         master    = i_cfg.enable & ~i_cfg.slave;
  wire         slave     = i_cfg.enable & i_cfg.slave;
  wire [3:0]   len_m1    = (i_cfg.len_m1 < SSP_LEN_MIN) ? SSP_LEN_MIN : i_cfg.len_m1;
  wire [7:0]   pre_eff   = (i_cfg.pre < SSP_PRE_MIN) ? SSP_PRE_MIN : i_cfg.pre;
  wire         frm_idle  = (i_cfg.fmt == SSP_FMT_SPI);
  wire         pre_wrap  = (pre_cnt_ff == pre_eff - 8'h01);
  wire         half_tick = pre_wrap & (div_cnt_ff == i_cfg.div);
  wire         rxd_s     = rxd_s_ff[1];
  // slave edges use only the second and third synchroniser stages
  wire         s_rise    = sclk_s_ff[1] & ~sclk_s_ff[2];
  wire         s_fall    = ~sclk_s_ff[1] & sclk_s_ff[2];
  wire         f_rise    = frm_s_ff[1] & ~frm_s_ff[2];
  wire         f_fall    = ~frm_s_ff[1] & frm_s_ff[2];
  wire         s_start   = (i_cfg.fmt == SSP_FMT_SELHI) ? f_rise : f_fall;
  wire         s_abort   = (i_cfg.fmt != SSP_FMT_PULSE) && (frm_s_ff[1] == frm_idle);
  wire         in_shift  = (state_ff == SSP_ST_SHIFT);
  wire         rise      = in_shift & (master ? (half_tick & ~phase_ff) : s_rise);
  wire         fall      = in_shift & (master ? (half_tick & phase_ff) : s_fall);
  wire         done      = fall & (bit_ff == len_m1);
  wire         tx_empty  = (tx_cnt_ff == 4'h0);
  wire         rx_full   = (rx_cnt_ff == SSP_FIFO_FULL);
  wire         m_start   = master & ~tx_empty & ~rx_full & (state_ff == SSP_ST_IDLE);
  wire         sl_start  = slave & s_start & (state_ff == SSP_ST_IDLE);
  wire         start     = m_start | sl_start;
  wire         tx_pop    = start & ~tx_empty;
  wire         tx_push   = i_tx_valid & o_tx_ready_ff;
  wire         rx_pop    = i_rx_ready & o_rx_valid_ff;
  wire         rx_push   = done & ~rx_full;
  wire [15:0]  tx_head   = tx_empty ? 16'h0000 : tx_mem_ff[tx_rd_ff];
  wire [15:0]  tx_align  = tx_head << (SSP_MSB - len_m1);
  wire [3:0]   tx_cnt_n  = tx_cnt_ff + {3'h0, tx_push} - {3'h0, tx_pop};
  wire [3:0]   rx_cnt_n  = rx_cnt_ff + {3'h0, rx_push} - {3'h0, rx_pop};
  wire [2:0]   rx_rd_n   = rx_pop ? ssp_inc(rx_rd_ff) : rx_rd_ff;
  wire [15:0]  rx_head_n = (rx_push && rx_wr_ff == rx_rd_n) ? sh_rx_ff : rx_mem_ff[rx_rd_n];

  // ----------------------------------------------------------------
  // shift engine
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_sh_tx = sh_tx_ff;
    nxt_sh_rx = sh_rx_ff;
    nxt_bit   = bit_ff;
    nxt_phase = phase_ff;
    case (state_ff)
      SSP_ST_IDLE: begin
        if (start) begin
          nxt_sh_tx = tx_align;
          nxt_sh_rx = 16'h0000;
          nxt_bit   = 4'h0;
          nxt_phase = 1'b0;
          nxt_state = (m_start && i_cfg.fmt == SSP_FMT_PULSE) ? SSP_ST_PULSE : SSP_ST_SHIFT;
        end
      end
      SSP_ST_PULSE: begin
        // pulse lasts one full bit time before the first data bit
        if (half_tick) begin
          nxt_phase = ~phase_ff;
          if (phase_ff) begin
            nxt_state = SSP_ST_SHIFT;
          end
        end
      end
      SSP_ST_SHIFT: begin
        if (!i_cfg.enable || (slave && s_abort)) begin
          nxt_state = SSP_ST_IDLE;
        end else if (rise) begin
          nxt_sh_rx = {sh_rx_ff[14:0], rxd_s};
          nxt_phase = 1'b1;
        end else if (fall) begin
          nxt_phase = 1'b0;
          nxt_sh_tx = {sh_tx_ff[14:0], 1'b0};
          nxt_bit   = bit_ff + 4'h1;
          if (done) begin
            nxt_state = master ? SSP_ST_GAP : SSP_ST_IDLE;
          end
        end
      end
      SSP_ST_GAP: begin
        // idle frame for one half bit so selects see a clean edge
        if (half_tick || !master) begin
          nxt_state = SSP_ST_IDLE;
        end
      end
      default: begin
        nxt_state = SSP_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      state_ff <= SSP_ST_IDLE;
      sh_tx_ff <= 16'h0000;
      sh_rx_ff <= 16'h0000;
      bit_ff   <= 4'h0;
      phase_ff <= 1'b0;
    end else if (i_ce) begin
      state_ff <= nxt_state;
      sh_tx_ff <= nxt_sh_tx;
      sh_rx_ff <= nxt_sh_rx;
      bit_ff   <= nxt_bit;
      phase_ff <= nxt_phase;
    end
  end

  // ----------------------------------------------------------------
  // master bit clock: prescaler then divider, half bit per tick
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn || (i_ce && (state_ff == SSP_ST_IDLE || !master))) begin
      pre_cnt_ff <= 8'h00;
      div_cnt_ff <= 8'h00;
    end else if (i_ce) begin
      pre_cnt_ff <= pre_wrap ? 8'h00 : pre_cnt_ff + 8'h01;
      div_cnt_ff <= half_tick ? 8'h00 : (pre_wrap ? div_cnt_ff + 8'h01 : div_cnt_ff);
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      sclk_s_ff <= 3'h0;
      frm_s_ff  <= 3'h7;
      rxd_s_ff  <= 2'h0;
    end else if (i_ce) begin
      sclk_s_ff <= {sclk_s_ff[1:0], i_sclk};
      frm_s_ff  <= {frm_s_ff[1:0], i_frm};
      rxd_s_ff  <= {rxd_s_ff[0], i_rxd};
    end
  end

  // ----------------------------------------------------------------
  // fifos
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      tx_wr_ff  <= 3'h0;
      tx_rd_ff  <= 3'h0;
      rx_wr_ff  <= 3'h0;
      rx_rd_ff  <= 3'h0;
      tx_cnt_ff <= 4'h0;
      rx_cnt_ff <= 4'h0;
    end else if (i_ce) begin
      if (tx_push) begin
        tx_mem_ff[tx_wr_ff] <= i_tx_data;
        tx_wr_ff            <= ssp_inc(tx_wr_ff);
      end
      if (tx_pop) begin
        tx_rd_ff <= ssp_inc(tx_rd_ff);
      end
      if (rx_push) begin
        rx_mem_ff[rx_wr_ff] <= sh_rx_ff;
        rx_wr_ff            <= ssp_inc(rx_wr_ff);
      end
      if (rx_pop) begin
        rx_rd_ff <= ssp_inc(rx_rd_ff);
      end
      tx_cnt_ff <= tx_cnt_n;
      rx_cnt_ff <= rx_cnt_n;
    end
  end

  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  wire frm_act = (i_cfg.fmt == SSP_FMT_PULSE) ? (nxt_state == SSP_ST_PULSE)
                 : (nxt_state == SSP_ST_SHIFT);
  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_tx_ready_ff <= 1'b0;
      o_rx_valid_ff <= 1'b0;
      o_rx_data_ff  <= 16'h0000;
      o_sclk_ff     <= 1'b0;
      o_frm_ff      <= 1'b1;
      o_txd_ff      <= 1'b0;
      o_sclk_oe_ff  <= 1'b0;
      o_frm_oe_ff   <= 1'b0;
      o_txd_oe_ff   <= 1'b0;
      o_busy_ff     <= 1'b0;
      o_overrun_ff  <= 1'b0;
    end else if (i_ce) begin
      o_tx_ready_ff <= (tx_cnt_n != SSP_FIFO_FULL);
      o_rx_valid_ff <= (rx_cnt_n != 4'h0);
      o_rx_data_ff  <= rx_head_n;
      o_sclk_ff     <= master & (nxt_state == SSP_ST_SHIFT) & nxt_phase;
      o_frm_ff      <= frm_act ? ~frm_idle : frm_idle;
      o_txd_ff      <= nxt_sh_tx[15];
      o_sclk_oe_ff  <= master;
      o_frm_oe_ff   <= master;
      // a muted slave leaves the shared receive line to its peers
      o_txd_oe_ff   <= master | (slave & ~i_cfg.out_dis & (nxt_state == SSP_ST_SHIFT));
      o_busy_ff     <= (nxt_state != SSP_ST_IDLE) | ~tx_empty;
      o_overrun_ff  <= done & rx_full;
    end
  end
  assign o_tx_ready = o_tx_ready_ff;
  assign o_rx_valid = o_rx_valid_ff;
  assign o_rx_data  = o_rx_data_ff;
  assign o_sclk     = o_sclk_ff;
  assign o_sclk_oe  = o_sclk_oe_ff;
  assign o_frm      = o_frm_ff;
  assign o_frm_oe   = o_frm_oe_ff;
  assign o_txd      = o_txd_ff;
  assign o_txd_oe   = o_txd_oe_ff;
  assign o_busy     = o_busy_ff;
  assign o_overrun  = o_overrun_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn || !i_ce);
  sequence pulse_begin_s;
    state_ff == SSP_ST_IDLE && nxt_state == SSP_ST_PULSE;
  endsequence
  tx_fifo_bound_a: assert property (tx_cnt_ff <= SSP_FIFO_FULL)
    else $error("tx fifo count above depth");
  tx_ready_full_a: assert property (tx_cnt_ff == SSP_FIFO_FULL |-> !o_tx_ready)
    else $error("tx ready while fifo full");
  word_length_a: assert property (fall && i_cfg.enable && !(slave && s_abort)
    |=> in_shift == ($past(bit_ff) != len_m1)) else $error("frame ended at wrong bit");
  rx_sample_a: assert property (rise |=> sh_rx_ff[0] == $past(rxd_s))
    else $error("receive bit not sampled");
  rx_push_cnt_a: assert property (rx_push && !rx_pop |=> rx_cnt_ff == $past(rx_cnt_ff) + 4'h1)
    else $error("received word not queued");
  sclk_tick_a: assert property (master && $changed(o_sclk) |-> $past(half_tick))
    else $error("serial clock moved off tick");
  slave_mute_a: assert property (slave && i_cfg.out_dis |=> !o_txd_oe)
    else $error("muted slave drives data");
  master_drive_a: assert property (master |=> o_sclk_oe && o_frm_oe)
    else $error("master not driving clock and frame");
  pulse_frame_a: assert property (pulse_begin_s |=> o_frm ##1 o_frm)
    else $error("frame pulse missing");
endmodule // ssp_core

// *** tb/ssp_peer.sv ***
// far-side peripheral model for frames where the port is master
// assumes mode 0: samples on rising sclk, changes its data on falling sclk
`timescale 1ns/100ps
module ssp_peer (
  // link
  input  wire logic        i_sclk,
  input  wire logic        i_frm,
  input  wire logic        i_txd,
  output logic             o_rxd,
  // bench control
  input  wire logic        i_load,
  input  wire logic [15:0] i_reply,
  input  wire logic [4:0]  i_len,
  output logic [15:0]      o_cap,
  output logic             o_frm_seen
);
  logic [15:0] rep_ff;
  logic [4:0]  cnt_ff;
  initial begin
    o_rxd = 1'b0;
    o_cap = 16'h0000;
    cnt_ff = 5'h00;
    rep_ff = 16'h0000;
    o_frm_seen = 1'b0;
  end
  always @(posedge i_load) begin
    rep_ff = i_reply << (5'h10 - i_len);
    o_rxd = rep_ff[15];
    cnt_ff = 5'h00;
  end
  always @(posedge i_sclk) begin
    o_cap = {o_cap[14:0], i_txd};
    if (cnt_ff == 5'h00) o_frm_seen = i_frm;
    cnt_ff = cnt_ff + 5'h01;
  end
  // after the last bit the word just taken is echoed next frame, so order shows
  always @(negedge i_sclk) begin
    rep_ff = (cnt_ff >= i_len) ? (o_cap << (5'h10 - i_len)) : (rep_ff << 1);
    if (cnt_ff >= i_len) cnt_ff = 5'h00;
    o_rxd = rep_ff[15];
  end
endmodule // ssp_peer

// *** tb/tb.sv ***
// self-checking bench for ssp_core: master formats, lengths, rates, fifos, slave
// assumes the peer model answers master frames; slave frames are driven here
`timescale 1ns/100ps
module tb;
  import ssp_pkg::*;
  logic i_clk_sys, i_resetn, tx_valid, rx_ready, s_sclk, s_frm, s_rxd, p_rxd, load;
  logic tx_ready, rx_valid, o_sclk, sclk_oe, o_frm, frm_oe, o_txd, txd_oe, busy, ovr;
  logic [15:0] tx_data, rx_data, reply, cap;
  logic [4:0]  len;
  logic        frm_seen;
  ssp_cfg_t    cfg;
  int          n_fail, samples_checked;
  int          n_ovr = 0;
  wire rxd = cfg.slave ? s_rxd : p_rxd;
  ssp_core dut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_ce(1'b1), .i_cfg(cfg),
    .i_tx_valid(tx_valid), .i_tx_data(tx_data), .o_tx_ready(tx_ready),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data), .i_rx_ready(rx_ready),
    .i_sclk(s_sclk), .o_sclk(o_sclk), .o_sclk_oe(sclk_oe), .i_frm(s_frm), .o_frm(o_frm),
    .o_frm_oe(frm_oe), .o_txd(o_txd), .o_txd_oe(txd_oe), .i_rxd(rxd), .o_busy(busy),
    .o_overrun(ovr));
  ssp_peer peer (.i_sclk(o_sclk), .i_frm(o_frm), .i_txd(o_txd), .o_rxd(p_rxd),
    .i_load(load), .i_reply(reply), .i_len(len), .o_cap(cap), .o_frm_seen(frm_seen));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end
  // overrun is a one-cycle pulse, so it is counted mid-cycle as it passes
  always @(negedge i_clk_sys) begin
    if (ovr === 1'b1) n_ovr <= n_ovr + 1;
  end
  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge i_clk_sys);
    #2;
  endtask
  task automatic bail();
    n_fail++;
    wrap_up();
  endtask
  task automatic setcfg(input logic s, d, input ssp_fmt_t f, input logic [3:0] l,
                        input logic [7:0] p, v);
    cfg = '{enable: 1'b1, slave: s, out_dis: d, fmt: f, len_m1: l, pre: p, div: v};
    len = (l < 4'h3) ? 5'h04 : {1'b0, l} + 5'h01;
  endtask
  // push holds valid and data until an edge sees ready high
  task automatic push(input logic [15:0] w);
    int i;
    tx_valid = 1'b1;
    tx_data = w;
    for (i = 0; i < 5000 && !tx_ready; i++) tick();
    if (i == 5000) bail();
    tick();
    tx_valid = 1'b0;
  endtask
  task automatic pop_chk(input logic [15:0] exp);
    int i;
    for (i = 0; i < 5000 && !rx_valid; i++) tick();
    if (i == 5000) bail();
    chk(rx_data, exp);
    rx_ready = 1'b1;
    @(posedge i_clk_sys);
    rx_ready <= 1'b0;
    #2;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic master_xfer(input ssp_fmt_t f, input logic [3:0] l, input logic [7:0] p, v,
                             input logic [15:0] w, input int hexp);
    int i, hi, seen;
    logic [15:0] m;
    setcfg(1'b0, 1'b0, f, l, p, v);
    m = 16'hFFFF >> (5'h10 - len);
    reply = ~w;
    load = 1'b1;
    tick();
    load = 1'b0;
    push(w);
    hi = 0;
    seen = 0;
    for (i = 0; i < 8000 && (i < 3 || busy); i++) begin
      tick();
      if (o_sclk && seen < 2) begin
        hi++;
        seen = 1;
      end else if (seen == 1) seen = 2;
    end
    if (i == 8000) bail();
    chk(16'(hi), 16'(hexp));
    chk({15'h0, sclk_oe & frm_oe}, 16'h0001);
    chk(cap & m, w & m);
    if (f != SSP_FMT_PULSE) chk({15'h0, frm_seen}, {15'h0, f == SSP_FMT_SELHI});
    pop_chk(~w & m);
  endtask
  task automatic fifo_fill();
    int n;
    setcfg(1'b0, 1'b0, SSP_FMT_SPI, 4'hF, 8'h10, 8'h03);
    reply = 16'h5A5A;
    load = 1'b1;
    tick();
    load = 1'b0;
    tx_valid = 1'b1;
    for (n = 0; n < 12 && tx_ready; n++) begin
      tx_data = 16'hA000 + 16'(n);
      tick();
    end
    tx_valid = 1'b0;
    chk({15'h0, n >= 8 && n <= 9}, 16'h0001);
    tick(3000);
    chk({15'h0, busy & ~rx_valid}, 16'h0000);
    pop_chk(16'h5A5A);
    for (int k = 0; k < 7; k++) pop_chk(16'hA000 + 16'(k));
    for (int k = 7; k < n - 1; k++) pop_chk(16'hA000 + 16'(k));
  endtask
  task automatic slave_xfer(input logic d, input logic [15:0] w, input logic [15:0] r);
    logic [15:0] got;
    setcfg(1'b1, d, SSP_FMT_SPI, 4'h7, 8'h02, 8'h00);
    push(w);
    tick(4);
    s_frm = 1'b0;
    tick(8);
    for (int b = 7; b >= 0; b--) begin
      s_rxd = r[b];
      tick(4);
      s_sclk = 1'b1;
      got = {got[14:0], o_txd};
      chk({14'h0, sclk_oe, txd_oe}, {15'h0, ~d});
      tick(4);
      s_sclk = 1'b0;
    end
    tick(4);
    s_frm = 1'b1;
    s_rxd = ~s_rxd;
    if (!d) chk(got & 16'h00FF, w & 16'h00FF);
    pop_chk(r & 16'h00FF);
    tick(10);
  endtask
  // nine slave frames with no pops: the ninth finds the receive fifo full
  task automatic slave_ovr();
    int n0;
    setcfg(1'b1, 1'b0, SSP_FMT_SPI, 4'h3, 8'h02, 8'h00);
    n0 = n_ovr;
    for (int f = 0; f < 9; f++) begin
      s_frm = 1'b0;
      tick(8);
      for (int b = 3; b >= 0; b--) begin
        s_rxd = f[b];
        tick(4);
        s_sclk = 1'b1;
        tick(4);
        s_sclk = 1'b0;
      end
      tick(4);
      s_frm = 1'b1;
      tick(8);
    end
    chk(16'(n_ovr - n0), 16'h0001);
    for (int f = 0; f < 8; f++) pop_chk(16'(f));
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    n_fail = 0;
    samples_checked = 0;
    {tx_valid, rx_ready, s_sclk, load, s_rxd} = 5'h00;
    s_frm = 1'b1;
    tx_data = 16'h0000;
    reply = 16'h0000;
    setcfg(1'b0, 1'b0, SSP_FMT_SPI, 4'h7, 8'h02, 8'h00);
    i_resetn = 1'b0;
    tick(6);
    i_resetn = 1'b1;
    tick(2);
    master_xfer(SSP_FMT_SPI, 4'h7, 8'h02, 8'h00, 16'h00C5, 3);
    master_xfer(SSP_FMT_PULSE, 4'h7, 8'h03, 8'h01, 16'h003A, 6);
    master_xfer(SSP_FMT_SELHI, 4'h7, 8'h00, 8'h02, 16'h0096, 9);
    master_xfer(SSP_FMT_SPI, 4'h1, 8'h02, 8'h00, 16'h000B, 3);
    master_xfer(SSP_FMT_SPI, 4'h3, 8'h02, 8'h01, 16'h0006, 6);
    master_xfer(SSP_FMT_SPI, 4'hF, 8'h02, 8'h00, 16'hB3C1, 3);
    fifo_fill();
    slave_xfer(1'b1, 16'h00E1, 16'h0069);
    slave_xfer(1'b0, 16'h00A3, 16'h0096);
    slave_ovr();
    wrap_up();
  end
endmodule // tb
